// ---- core/hprm_defines.vh ----
// Constants for the handpad rate and mode control block.
// Assumes a 250 MHz system clock; included by bare name from core files.
`ifndef HPRM_DEFINES_VH
`define HPRM_DEFINES_VH
// Clock period in nanoseconds.
`define HPRM_CLK_NS 4
// Centre button hold time in microseconds (a quarter second).
`define HPRM_HOLD_US 250000
// Hold time as cycles, rounded up; worked in nanoseconds so it fits 32-bit arithmetic.
`define HPRM_HOLD_CYC ((`HPRM_HOLD_US * 1000 + `HPRM_CLK_NS - 1) / `HPRM_CLK_NS)
// Register word indices.
`define HPRM_OFS_CTRL 4'h0
`define HPRM_OFS_SLEW 4'h1
`define HPRM_OFS_PAN 4'h2
`define HPRM_OFS_GUIDE 4'h3
`define HPRM_OFS_ACCEL 4'h4
`define HPRM_OFS_STATUS 4'h5
`define HPRM_OFS_ALT_POS 4'h6
`define HPRM_OFS_AZ_POS 4'h7
// Control register fields.
`define HPRM_CTRL_PADTYPE_LSB 0
`define HPRM_CTRL_INV_ALT 2
`define HPRM_CTRL_INV_AZ 3
// Pad types.
`define HPRM_PAD_OLD 2'h0
`define HPRM_PAD_NEW 2'h1
`define HPRM_PAD_RADIO 2'h2
// Speed modes.
`define HPRM_MODE_SLEW 2'h0
`define HPRM_MODE_PAN 2'h1
`define HPRM_MODE_GUIDE 2'h2
// Reset values.
`define HPRM_RST_CTRL 32'h00000001
`define HPRM_RST_ACCEL 32'h000004b0
`define HPRM_RST_RATE 32'h00000000
`endif

// ---- core/hprm_quad_counter.v ----
// Quadrature counter for one telescope encoder axis.
// Assumes A and B come from pins and are synchronised here.
`timescale 1ns/100ps
`include "hprm_defines.vh"
module hprm_quad_counter #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst,
  input wire enc_a,
  input wire enc_b,
  input wire invert,
  output reg [WIDTH-1:0] count_reg
);
  reg [2:0] a_sync_reg;
  reg [2:0] b_sync_reg;
  reg [1:0] state_reg;
  wire [1:0] state_next;
  wire step;
  wire up;

  ////////////////////////////////////////////////////////////////////////
  // Three stages; a level counts once stages two and three agree.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_sync_reg <= 3'h0;
      b_sync_reg <= 3'h0;
      state_reg <= 2'h0;
    end else begin
      a_sync_reg <= {a_sync_reg[1:0], enc_a};
      b_sync_reg <= {b_sync_reg[1:0], enc_b};
      state_reg <= state_next;
    end
  end

  // Stage 0 is read only by stage 1, so it never reaches the decoder.
  assign state_next[1] = (a_sync_reg[1] == a_sync_reg[2]) ? a_sync_reg[2] : state_reg[1];
  assign state_next[0] = (b_sync_reg[1] == b_sync_reg[2]) ? b_sync_reg[2] : state_reg[0];
  // One decoded step per cycle at 250 MHz is far above any 500,000 tick wheel rate.
  assign step = state_next != state_reg;
  assign up = (state_reg[1] ^ state_next[0]) ^ invert;

  ////////////////////////////////////////////////////////////////////////
  // Position accumulator.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (step) begin
      count_reg <= up ? count_reg + 1'b1 : count_reg - 1'b1;
    end
  end
endmodule

// ---- core/hprm_top.v ----
// Handpad rate and mode control: keys to axis velocity commands with ramp.
// Assumes an Avalon-MM master on the same clock and pins from the handpad.
// Key and encoder pins are asynchronous to the clock and are synchronised inside.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "hprm_defines.vh"
// Function
// - New pad: holding centre button a quarter second toggles slew and pan.
// - Momentary speed button becomes an internally latched mode selection.
// - Radio pad: each speed key press steps slew, pan, guide; mode is shown.
// - New and radio pads accept combined keys, moving both axes together.
// - Acceleration value sets ramp steepness; larger means faster ramp.
// - Each axis may invert the telescope encoder count direction.
// - Telescope encoder ticks are counted without loss up to 500,000 per rev.
module hprm_top #(
  parameter HOLD_CYC = `HPRM_HOLD_CYC,
  parameter RATE_W = 32
) (
  input wire CLOCK,
  input wire RST,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output wire [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire KEY_UP,
  input wire KEY_DOWN,
  input wire KEY_LEFT,
  input wire KEY_RIGHT,
  input wire SPEED_SELECT_KEY,
  input wire ALT_ENC_A,
  input wire ALT_ENC_B,
  input wire AZ_ENC_A,
  input wire AZ_ENC_B,
  output wire [1:0] MODE_IND,
  output reg [RATE_W-1:0] ALT_RATE,
  output reg [RATE_W-1:0] AZ_RATE
);
  reg [31:0] ctrl_reg;
  reg [31:0] slew_reg;
  reg [31:0] pan_reg;
  reg [31:0] guide_reg;
  reg [31:0] accel_reg;
  reg [31:0] rdata_reg;
  reg ack_reg;
  wire [4:0] key_reg;
  reg [31:0] hold_cnt_reg;
  reg hold_done_reg;
  reg spd_prev_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg signed [RATE_W-1:0] alt_tgt;
  reg signed [RATE_W-1:0] az_tgt;
  reg signed [RATE_W-1:0] sel_rate;
  wire [4:0] key_pins;
  wire [1:0] pad_type;
  wire [31:0] alt_pos;
  wire [31:0] az_pos;
  wire req;
  genvar gi;

  // Byte-lane merge used by every writable register.
  // Lanes whose byte enable is low keep their old contents.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // Moves a rate toward its target by at most one acceleration step.
  // The difference is taken one bit wider so that a full-scale reversal cannot wrap.
  // A step wider than the rate field is cut to the field; software keeps it small.
  function signed [RATE_W-1:0] ramp;
    input signed [RATE_W-1:0] cur;
    input signed [RATE_W-1:0] tgt;
    input [31:0] step;
    reg signed [RATE_W:0] diff;
    begin
      diff = {tgt[RATE_W-1], tgt} - {cur[RATE_W-1], cur};
      if (diff > $signed({1'b0, step[RATE_W-1:0]})) begin
        ramp = cur + step[RATE_W-1:0];
      end else if (diff < -$signed({1'b0, step[RATE_W-1:0]})) begin
        ramp = cur - step[RATE_W-1:0];
      end else begin
        ramp = tgt;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer on the next edge.
  // Word map: 0 control, 1 slew rate, 2 pan rate, 3 guide rate, 4 acceleration step,
  // 5 status (mode in bits 1:0, synchronised keys above), 6 and 7 telescope positions.
  // Control holds the pad type in bits 1:0 and the two count inversions in bits 3:2.
  // Read data is captured while waitrequest is high, so it already stands at the
  // edge where the master sees waitrequest low.
  // Writes land at that same edge; a master that broke the protocol by dropping a
  // request early would therefore leave every register untouched.
  // The fixed single wait state costs one cycle per access but needs no state machine.
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign AVS_READDATA = rdata_reg;
  assign pad_type = ctrl_reg[`HPRM_CTRL_PADTYPE_LSB +: 2];

  // Register writes and read capture; unmapped reads return zero.
  // A write takes effect only at the edge where waitrequest is low.
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `HPRM_RST_CTRL;
      slew_reg <= `HPRM_RST_RATE;
      pan_reg <= `HPRM_RST_RATE;
      guide_reg <= `HPRM_RST_RATE;
      accel_reg <= `HPRM_RST_ACCEL;
      rdata_reg <= 32'h00000000;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (ack_reg & AVS_WRITE) begin
        case (AVS_ADDRESS)
          `HPRM_OFS_CTRL: begin
            ctrl_reg <= merge(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000000f;
          end
          `HPRM_OFS_SLEW: slew_reg <= merge(slew_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `HPRM_OFS_PAN: pan_reg <= merge(pan_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `HPRM_OFS_GUIDE: guide_reg <= merge(guide_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          `HPRM_OFS_ACCEL: accel_reg <= merge(accel_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
      if (req & ~ack_reg & AVS_READ) begin
        case (AVS_ADDRESS)
          `HPRM_OFS_CTRL: rdata_reg <= ctrl_reg;
          `HPRM_OFS_SLEW: rdata_reg <= slew_reg;
          `HPRM_OFS_PAN: rdata_reg <= pan_reg;
          `HPRM_OFS_GUIDE: rdata_reg <= guide_reg;
          `HPRM_OFS_ACCEL: rdata_reg <= accel_reg;
          `HPRM_OFS_STATUS: rdata_reg <= {25'h0, key_reg, mode_reg};
          `HPRM_OFS_ALT_POS: rdata_reg <= alt_pos;
          `HPRM_OFS_AZ_POS: rdata_reg <= az_pos;
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Key synchronisers: three stages, a change counts when stages 1 and 2 agree.
  // The idle level of every key is low, which is also the reset value, so no false
  // press or speed-key edge follows reset.
  assign key_pins = {SPEED_SELECT_KEY, KEY_RIGHT, KEY_LEFT, KEY_DOWN, KEY_UP};
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_key
      reg [2:0] sync_reg;
      reg level_reg;
      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          sync_reg <= 3'h0;
          level_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[1:0], key_pins[gi]};
          if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
          end
        end
      end
      // Each key keeps its own flops, so every bit of the key vector has one driver.
      assign key_reg[gi] = level_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Speed mode latch. Old pad has a real switch, so its level is the mode.
  // New and radio pads only give a momentary button, so the mode lives in mode_reg
  // and survives the release of the key.
  always @* begin
    mode_next = mode_reg;
    case (pad_type)
      `HPRM_PAD_OLD: begin
        mode_next = key_reg[4] ? `HPRM_MODE_PAN : `HPRM_MODE_SLEW;
      end
      `HPRM_PAD_NEW: begin
        // Toggle once per hold; a longer hold does not toggle again.
        if (key_reg[4] && !hold_done_reg && hold_cnt_reg == HOLD_CYC - 1) begin
          mode_next = (mode_reg == `HPRM_MODE_SLEW) ? `HPRM_MODE_PAN : `HPRM_MODE_SLEW;
        end
      end
      `HPRM_PAD_RADIO: begin
        if (key_reg[4] && !spd_prev_reg) begin
          case (mode_reg)
            `HPRM_MODE_SLEW: mode_next = `HPRM_MODE_PAN;
            `HPRM_MODE_PAN: mode_next = `HPRM_MODE_GUIDE;
            default: mode_next = `HPRM_MODE_SLEW;
          endcase
        end
      end
      default: mode_next = mode_reg;
    endcase
  end

  // Hold counter and mode state.
  // The counter stops at the hold time, so a key held for minutes neither wraps
  // nor toggles the mode a second time.
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      hold_cnt_reg <= 32'h00000000;
      hold_done_reg <= 1'b0;
      spd_prev_reg <= 1'b0;
      mode_reg <= `HPRM_MODE_SLEW;
    end else begin
      spd_prev_reg <= key_reg[4];
      mode_reg <= mode_next;
      if (!key_reg[4]) begin
        hold_cnt_reg <= 32'h00000000;
        hold_done_reg <= 1'b0;
      end else if (hold_cnt_reg == HOLD_CYC - 1) begin
        hold_done_reg <= 1'b1;
      end else if (!hold_done_reg) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
      end
    end
  end

  // Mode indication is shown for the radio receiver.
  // The code equals the mode register, so software sees the same value in status.
  assign MODE_IND = mode_reg;

  ////////////////////////////////////////////////////////////////////////
  // Target velocity per axis from held keys and the selected rate.
  // Up and right are positive; opposing keys on one axis cancel to a stop rather
  // than guessing which press was meant.
  // Old pad rates are taken as signed, so software supplies negatives there.
  always @* begin
    case (mode_reg)
      `HPRM_MODE_PAN: sel_rate = pan_reg[RATE_W-1:0];
      `HPRM_MODE_GUIDE: sel_rate = guide_reg[RATE_W-1:0];
      default: sel_rate = slew_reg[RATE_W-1:0];
    endcase
    alt_tgt = {RATE_W{1'b0}};
    az_tgt = {RATE_W{1'b0}};
    if (key_reg[0] != key_reg[1]) begin
      alt_tgt = key_reg[0] ? sel_rate : -sel_rate;
    end
    if (key_reg[2] != key_reg[3]) begin
      az_tgt = key_reg[3] ? sel_rate : -sel_rate;
    end
    // Old pad cannot combine axes; altitude takes precedence.
    if (pad_type == `HPRM_PAD_OLD && alt_tgt != {RATE_W{1'b0}}) begin
      az_tgt = {RATE_W{1'b0}};
    end
  end

  // Ramp toward the targets by the acceleration step each cycle.
  // Releasing a key ramps the axis down the same way, so the mount never sees a
  // step change of velocity.
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ALT_RATE <= {RATE_W{1'b0}};
      AZ_RATE <= {RATE_W{1'b0}};
    end else begin
      ALT_RATE <= ramp(ALT_RATE, alt_tgt, accel_reg);
      AZ_RATE <= ramp(AZ_RATE, az_tgt, accel_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Telescope encoder counters with per-axis inversion.
  // Inversion only flips the counting sense; swapping the A and B wires does the
  // same job without software, which is why both axes reset to no inversion.
  hprm_quad_counter #(.WIDTH(32)) u_alt (
    .clk(CLOCK),
    .rst(RST),
    .enc_a(ALT_ENC_A),
    .enc_b(ALT_ENC_B),
    .invert(ctrl_reg[`HPRM_CTRL_INV_ALT]),
    .count_reg(alt_pos)
  );

  hprm_quad_counter #(.WIDTH(32)) u_az (
    .clk(CLOCK),
    .rst(RST),
    .enc_a(AZ_ENC_A),
    .enc_b(AZ_ENC_B),
    .invert(ctrl_reg[`HPRM_CTRL_INV_AZ]),
    .count_reg(az_pos)
  );
endmodule

// ---- testbench/hprm_pad_model.sv ----
// Handpad and telescope encoder model: key pins and quadrature steps.
// Assumes the bench sets press and step just after a rising edge.
`timescale 1ns/100ps
module hprm_pad_model #(
  parameter longint TX_OFF_CYC = 64'd450000000000,
  parameter longint LIGHT_OFF_CYC = 64'd225000000000
) (
  input logic CLOCK,
  input logic lock,
  input logic [4:0] press,
  input logic [1:0] step,
  output logic [4:0] keys,
  output logic [1:0] enc_a,
  output logic [1:0] enc_b
);
  logic [1:0] ph [2] = '{2'h0, 2'h0};
  logic [1:0] div = 2'h0;
  longint age = 0;
  logic light_on;
  // Sixteen light levels, never reset, so the level survives a power loss.
  logic [3:0] light_lvl = 4'h8;
  // Pins are low whenever nothing is pressed or the transmitter has timed out.
  // With the lock on, only the four direction keys reach the pins.
  assign keys = (age >= TX_OFF_CYC) ? 5'h00 : (lock ? (press & 5'h0f) : press);
  // The light goes dark at its own time-out; runs here are far shorter than both.
  assign light_on = age < LIGHT_OFF_CYC;
  // One quadrature state per four clocks, well inside the counting limit.
  always @(posedge CLOCK) begin
    age <= age + 1;
    div <= div + 2'h1;
    for (int i = 0; i < 2; i++)
      if (step[i] && div == 2'h3) ph[i] <= ph[i] + 2'h1;
  end
  // Gray order 00, 10, 11, 01 so A leads B.
  assign enc_a = {ph[1][0] ^ ph[1][1], ph[0][0] ^ ph[0][1]};
  assign enc_b = {ph[1][1], ph[0][1]};
endmodule

// ---- testbench/hprm_top_asserts.sv ----
// Checker for the handpad block: bus handshake, mode and idle-rate relations.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/100ps
module hprm_top_asserts #(
  parameter RATE_W = 32
) (
  input logic CLOCK,
  input logic RST,
  input logic [3:0] AVS_ADDRESS,
  input logic AVS_READ,
  input logic AVS_WRITE,
  input logic [31:0] AVS_READDATA,
  input logic AVS_WAITREQUEST,
  input logic KEY_UP,
  input logic KEY_DOWN,
  input logic KEY_LEFT,
  input logic KEY_RIGHT,
  input logic SPEED_SELECT_KEY,
  input logic [1:0] MODE_IND,
  input logic [RATE_W-1:0] ALT_RATE,
  input logic [RATE_W-1:0] AZ_RATE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // The slave answers every request after exactly one wait cycle.
  AST_WAIT_IDLE: assert property (AVS_WAITREQUEST |-> (AVS_READ || AVS_WRITE))
    else $error("waitrequest high without a request");
  AST_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");
  AST_HOLE_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 4'h7
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  ////////////////////////////////////////////////////////////////////////////
  // Mode only moves on speed key activity or a switch to the old pad; the key lags four edges and the mode one
  // more, hence six.
  AST_MODE_LEGAL: assert property (MODE_IND != 2'h3)
    else $error("illegal mode code");
  AST_MODE_STABLE: assert property (!SPEED_SELECT_KEY [*6] |=> $stable(MODE_IND))
    else $error("mode changed with speed key released");
  AST_ALT_IDLE: assert property ((!KEY_UP && !KEY_DOWN) [*4] ##0 ALT_RATE == '0
    |=> ALT_RATE == '0) else $error("altitude moved with no key");
  AST_AZ_IDLE: assert property ((!KEY_LEFT && !KEY_RIGHT) [*4] ##0 AZ_RATE == '0
    |=> AZ_RATE == '0) else $error("azimuth moved with no key");
  // Main scenarios.
  CV_READ: cover property (AVS_READ && !AVS_WAITREQUEST);
  CV_GUIDE: cover property (MODE_IND == 2'h2);
  CV_BOTH: cover property (ALT_RATE != '0 && AZ_RATE != '0);
endmodule
bind hprm_top hprm_top_asserts #(.RATE_W(RATE_W)) u_asserts (.CLOCK(CLOCK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .KEY_UP(KEY_UP),
  .KEY_DOWN(KEY_DOWN), .KEY_LEFT(KEY_LEFT), .KEY_RIGHT(KEY_RIGHT),
  .SPEED_SELECT_KEY(SPEED_SELECT_KEY), .MODE_IND(MODE_IND), .ALT_RATE(ALT_RATE),
  .AZ_RATE(AZ_RATE));

// ---- testbench/testbench.sv ----
// Self-checking bench for the handpad rate and mode block.
// Assumes the pad model drives keys and encoders, the bench drives the bus.
`timescale 1ns/100ps
module testbench;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [4:0] press = 5'h0;
  logic lock = 1'b0;
  logic [1:0] step = 2'h0;
  wire [31:0] rdat, alt, az;
  wire wreq;
  wire [4:0] keys;
  wire [1:0] ea, eb, mode;
  int error_cnt = 0;
  int cmp_count = 0;
  hprm_top #(.HOLD_CYC(20)) u_hprm_top (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .KEY_UP(keys[0]), .KEY_DOWN(keys[1]),
    .KEY_LEFT(keys[2]), .KEY_RIGHT(keys[3]), .SPEED_SELECT_KEY(keys[4]), .ALT_ENC_A(ea[0]),
    .ALT_ENC_B(eb[0]), .AZ_ENC_A(ea[1]), .AZ_ENC_B(eb[1]), .MODE_IND(mode), .ALT_RATE(alt),
    .AZ_RATE(az));
  hprm_pad_model u_hprm_pad_model (.CLOCK(CLOCK), .press(press), .step(step), .keys(keys),
    .enc_a(ea), .enc_b(eb), .lock(lock));
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers; rate and mode outputs are sampled at falling edges where they are settled.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge CLOCK);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are both taken at the rising edge; only the watchdog
    // ends a wait that never finishes.
    do begin @(posedge CLOCK); end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic pr(input logic [4:0] p);
    @(posedge CLOCK);
    press <= p;
  endtask
  task automatic nc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  // Waits, bounded, for the altitude rate to leave a value.
  task automatic wchg(input logic [31:0] v);
    int n = 0;
    do begin @(negedge CLOCK); n++; end while (alt === v && n < 20);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc("ctrl_rst", 4'h0, 32'h1);
    rdc("accel_rst", 4'h4, 32'h4b0);
    rdc("slew_rst", 4'h1, 32'h0);
    wrr(4'ha, 32'h5);
    rdc("hole", 4'ha, 32'h0);
    wrr(4'h0, 32'hfd);
    rdc("ctrl_bits", 4'h0, 32'hd);
    wrr(4'h0, 32'h1);
  endtask
  // Ramp steps by the acceleration value each cycle, up and then down.
  task automatic t_ramp;
    wrr(4'h1, 32'h1770);
    wrr(4'h4, 32'h3e8);
    pr(5'h1);
    wchg(32'h0);
    chk("alt_ramp1", 32'h3e8, alt);
    nc(1);
    chk("alt_ramp2", 32'h7d0, alt);
    nc(10);
    chk("alt_top", 32'h1770, alt);
    chk("az_idle", 32'h0, az);
    wrr(4'h4, 32'hbb8);
    press <= 5'h0;
    wchg(32'h1770);
    chk("alt_fall", 32'hbb8, alt);
    nc(1);
    chk("alt_stop", 32'h0, alt);
  endtask
  // Old pad: negative rates, altitude only when combined, switch level picks pan.
  task automatic t_old;
    wrr(4'h0, 32'h0);
    wrr(4'h1, 32'hffffe890);
    wrr(4'h2, 32'hfffff448);
    pr(5'h9);
    nc(30);
    chk("old_alt", 32'hffffe890, alt);
    chk("old_az", 32'h0, az);
    pr(5'h19);
    nc(30);
    chk("old_pan", 32'hfffff448, alt);
    chk("old_mode", 32'h1, {30'h0, mode});
    pr(5'h0);
    nc(30);
  endtask
  // New pad: both axes at once; a long hold toggles once, a short one never.
  task automatic t_new;
    wrr(4'h0, 32'h1);
    wrr(4'h1, 32'h1770);
    wrr(4'h2, 32'hbb8);
    pr(5'h9);
    nc(30);
    chk("new_alt", 32'h1770, alt);
    chk("new_az", 32'h1770, az);
    pr(5'h10);
    nc(10);
    pr(5'h0);
    nc(10);
    chk("short_hold", 32'h0, {30'h0, mode});
    pr(5'h10);
    nc(60);
    chk("long_hold", 32'h1, {30'h0, mode});
    pr(5'h1);
    nc(30);
    chk("pan_alt", 32'hbb8, alt);
    rdc("status", 4'h5, 32'h5);
    pr(5'h0);
    nc(30);
  endtask
  // Radio pad: speed key steps the modes, guide uses its own rate, the lock holds pan.
  task automatic t_radio;
    wrr(4'h0, 32'h2);
    wrr(4'h3, 32'h3e8);
    for (int i = 0; i < 3; i++) begin
      pr(5'h10);
      nc(8);
      pr(5'h0);
      nc(8);
      chk("radio_mode", (2 + i) % 3, {30'h0, mode});
      if (i == 0) begin
        pr(5'h1);
        nc(10);
        chk("guide_alt", 32'h3e8, alt);
        pr(5'h0);
        nc(10);
      end
    end
    @(posedge CLOCK);
    lock <= 1'b1;
    pr(5'h10);
    nc(8);
    pr(5'h0);
    lock <= 1'b0;
    nc(8);
    chk("radio_lock", 32'h1, {30'h0, mode});
  endtask
  // Eight encoder states per axis, then the same with the count inverted.
  task automatic t_enc;
    logic [31:0] p0, p1, p2, d1;
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, 4'h6 + i[3:0], 32'h0, p0);
      for (int k = 0; k < 2; k++) begin
        if (k == 1) wrr(4'h0, 32'h1 | (32'h4 << i));
        @(posedge CLOCK);
        step <= 2'h1 << i;
        nc(32);
        @(posedge CLOCK);
        step <= 2'h0;
        nc(10);
        bus(1'b0, 4'h6 + i[3:0], 32'h0, p2);
        if (k == 0) p1 = p2;
      end
      d1 = p1 - p0;
      chk("enc_cnt", 32'h8, d1[31] ? -d1 : d1);
      chk("enc_inv", -d1, p2 - p1);
      wrr(4'h0, 32'h1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin forever #2 CLOCK = ~CLOCK; end
  // Main sequence; old pad runs before new so the mode starts at slew.
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    t_regs;
    t_ramp;
    t_old;
    t_new;
    t_radio;
    t_enc;
    conclude;
  end
  // The tests take a few hundred cycles; this cuts a hang at 50k cycles.
  initial begin
    #200000;
    error_cnt++;
    conclude;
  end
endmodule
